// ===== verilog/psp_consts.vh
// What this block does
// [RL1] An 18-bit data word may be loaded and applied with no control word
// [RL2] Source supplies a control word for external reference or current limit
// [RL3] Word split is 16 data plus 8 control, or 18 data plus 6 control
// [RL4] Binary targets take the 16-bit or 18-bit data format by configuration
// [RL5] Data word bits read positive-true or negative-true by configuration
// [RL6] Positive-true means high is one; negative-true inverts the mapping
// [RL7] Control word polarity is configured independently of data polarity
// [RL8] Polarity bit comes from BCD bit 17, control word, or binary bit 15
// [RL9] Asynchronous standby/operate line switches the mode at once
// [RL10] Synchronous standby/operate is control word bit 0, applied on transfer
// [RL11] Standby/operate sense is configurable: asserted means standby or operate
// [RL12] Single-strobe: strobe control level at each pulse picks the word loaded
// [RL13] Configuration picks whether high strobe control loads control or data
// [RL14] Dual-strobe: data strobe loads data, control strobe loads control only
// [RL15] Source holds each control strobe at least 500 ns after word is set up
// [RL16] Source holds each data strobe at least 500 ns after word is set up
// [RL17] Each strobe is configurable as a positive-going or negative-going pulse
// [RL18] Source should use dual-strobe with BCD; binary may use either mode
// [RL19] Transfer trigger is control strobe only, data strobe only, or either
// [RL20] Option keeps the last data bit uncomplemented or complements it too; the keep option acts only in binary mode
// [RL21] Address enable active level is configurable positive or negative
// [RL22] Words load only while the address enable is active at the strobe
// [RL23] Transfer starts after a delay from trailing edge; outputs change at end
// [RL24] Ready is low while the block still acts on a previous strobe
// [RL25] Strobe, strobe control and address are synchronised, edges after polarity
`ifndef PSP_CONSTS_VH
`define PSP_CONSTS_VH

// Register byte offsets
`define PSP_OFF_CFG      8'h00
`define PSP_OFF_STAT     8'h04
`define PSP_OFF_DATA     8'h08
`define PSP_OFF_CTRL     8'h0C

// Configuration fields
`define PSP_CFG_LEN18    0
`define PSP_CFG_BINARY   1
`define PSP_CFG_DATA_NEG 2
`define PSP_CFG_CTRL_NEG 3
`define PSP_CFG_POL_LO   4
`define PSP_CFG_POL_HI   5
`define PSP_CFG_SO_SYNC  6
`define PSP_CFG_SO_STBY  7
`define PSP_CFG_SINGLE   8
`define PSP_CFG_SC_CTRL  9
`define PSP_CFG_CWS_NEG  10
`define PSP_CFG_DWS_NEG  11
`define PSP_CFG_TRG_LO   12
`define PSP_CFG_TRG_HI   13
`define PSP_CFG_KEEP     14
`define PSP_CFG_ADR_NEG  15
`define PSP_CFG_RESET    16'h0000

// Status fields
`define PSP_ST_READY     0
`define PSP_ST_BUSY      1
`define PSP_ST_STBY      2
`define PSP_ST_RUNT      3
`define PSP_ST_IGN       4
`define PSP_ST_ADDR      5

// Polarity bit source and trigger select codes
`define PSP_POL_BCD18    2'b00
`define PSP_POL_CTRL     2'b01
`define PSP_POL_BIN16    2'b10
`define PSP_TRG_CWS      2'b00
`define PSP_TRG_DWS      2'b01
`define PSP_TRG_ANY      2'b10

// Timing
`define PSP_CLK_NS       8
`define PSP_STB_MIN_NS   500
`define PSP_STB_MIN_CYC  ((`PSP_STB_MIN_NS + `PSP_CLK_NS - 1) / `PSP_CLK_NS)
`define PSP_DLY_NS       1000
`define PSP_DLY_CYC      ((`PSP_DLY_NS + `PSP_CLK_NS - 1) / `PSP_CLK_NS)
`define PSP_XFER_NS      24000
`define PSP_XFER_CYC     ((`PSP_XFER_NS + `PSP_CLK_NS - 1) / `PSP_CLK_NS)

`endif

// ===== verilog/psp_strobe.v
`timescale 1ns/1ps
`include "psp_consts.vh"

module psp_strobe (
  input  wire clock_i,
  input  wire rstn_i,
  input  wire raw_i,
  input  wire neg_i,
  output wire level_o,
  output wire lead_o,
  output wire trail_o,
  output wire runt_o
);

  localparam integer MIN_INT = `PSP_STB_MIN_CYC;
  localparam [6:0]   MIN_CYC = MIN_INT[6:0];

  reg       sync_a;
  reg       sync_b;
  reg       prev;
  reg [6:0] width;

  // Two-flop synchroniser; only sync_b looks at sync_a
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
      prev   <= level_o;
    end
  end

  // Polarity applied before edge detection
  assign level_o = sync_b ^ neg_i; // [RL25] [RL17]
  assign lead_o  = level_o & ~prev; // [RL25]
  assign trail_o = ~level_o & prev;

  // Pulse width; saturates so long pulses never wrap into runts
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      width <= 7'h00;
    end else if (lead_o) begin
      width <= 7'h01;
    end else if (level_o && width != 7'h7F) begin
      width <= width + 7'h01;
    end
  end

  assign runt_o = trail_o & (width < MIN_CYC); // [RL15] [RL16]

endmodule

// ===== verilog/psp_port.v
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "psp_consts.vh"

module psp_port (
  input  wire        clock_i,
  input  wire        rstn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [23:0] prog_bus_i,
  input  wire        cws_i,
  input  wire        dws_i,
  input  wire        strobe_ctl_i,
  input  wire        addr_en_i,
  input  wire        stby_op_i,
  output reg         ready_o,
  output reg  [17:0] out_data_o,
  output reg  [7:0]  out_ctrl_o,
  output reg         out_polarity_o,
  output reg         standby_o,
  output reg         xfer_done_o
);

  localparam [1:0]  ST_IDLE  = 2'b00;
  localparam [1:0]  ST_DELAY = 2'b01;
  localparam [1:0]  ST_SHIFT = 2'b10;
  localparam integer DLY_INT  = `PSP_DLY_CYC;
  localparam integer XFER_INT = `PSP_XFER_CYC;
  localparam [11:0] DLY_CYC  = DLY_INT[11:0];
  localparam [11:0] XFER_CYC = XFER_INT[11:0];

  // Polarity fix, with a mask of bits that stay uncomplemented
  function [17:0] psp_fix;
    input [17:0] word;
    input        inv;
    input [17:0] keep;
    input [17:0] width;
    begin
      psp_fix = (word ^ ({18{inv}} & ~keep)) & width;
    end
  endfunction

  reg         rst_q1;
  reg         rst_q2;
  wire        rst_n;
  reg  [15:0] cfg;
  reg  [17:0] data_st;
  reg  [7:0]  ctrl_st;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [11:0] cnt;
  reg         cws_acc;
  reg         dws_acc;
  reg         runt_flag;
  reg         ign_flag;
  wire        cws_lvl;
  wire        cws_lead;
  wire        cws_trail;
  wire        cws_runt;
  wire        dws_lvl;
  wire        dws_lead;
  wire        dws_trail;
  wire        dws_runt;
  wire        sc_lvl;
  wire        adr_lvl;
  wire        so_lvl;

  // Reset released through two flops so release is clean
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  assign rst_n = rst_q2;

  // Configuration fields
  wire       len18    = cfg[`PSP_CFG_LEN18];
  wire       binary   = cfg[`PSP_CFG_BINARY];
  wire       data_neg = cfg[`PSP_CFG_DATA_NEG];
  wire       ctrl_neg = cfg[`PSP_CFG_CTRL_NEG];
  wire [1:0] pol_sel  = cfg[`PSP_CFG_POL_HI:`PSP_CFG_POL_LO];
  wire       so_sync  = cfg[`PSP_CFG_SO_SYNC];
  wire       so_stby  = cfg[`PSP_CFG_SO_STBY];
  wire       single   = cfg[`PSP_CFG_SINGLE];
  wire       sc_ctrl  = cfg[`PSP_CFG_SC_CTRL];
  wire [1:0] trg_sel  = cfg[`PSP_CFG_TRG_HI:`PSP_CFG_TRG_LO];
  wire       keep     = cfg[`PSP_CFG_KEEP];

  // Synchronised strobe and level inputs
  psp_strobe u_cws (
    .clock_i (clock_i),
    .rstn_i  (rst_n),
    .raw_i   (cws_i),
    .neg_i   (cfg[`PSP_CFG_CWS_NEG]),
    .level_o (cws_lvl),
    .lead_o  (cws_lead),
    .trail_o (cws_trail),
    .runt_o  (cws_runt)
  );

  psp_strobe u_dws (
    .clock_i (clock_i),
    .rstn_i  (rst_n),
    .raw_i   (dws_i),
    .neg_i   (cfg[`PSP_CFG_DWS_NEG]),
    .level_o (dws_lvl),
    .lead_o  (dws_lead),
    .trail_o (dws_trail),
    .runt_o  (dws_runt)
  );

  psp_strobe u_sc (
    .clock_i (clock_i),
    .rstn_i  (rst_n),
    .raw_i   (strobe_ctl_i),
    .neg_i   (1'b0),
    .level_o (sc_lvl),
    .lead_o  (),
    .trail_o (),
    .runt_o  ()
  );

  psp_strobe u_adr (
    .clock_i (clock_i),
    .rstn_i  (rst_n),
    .raw_i   (addr_en_i),
    .neg_i   (cfg[`PSP_CFG_ADR_NEG]), // [RL21]
    .level_o (adr_lvl),
    .lead_o  (),
    .trail_o (),
    .runt_o  ()
  );

  psp_strobe u_so (
    .clock_i (clock_i),
    .rstn_i  (rst_n),
    .raw_i   (stby_op_i),
    .neg_i   (1'b0),
    .level_o (so_lvl),
    .lead_o  (),
    .trail_o (),
    .runt_o  ()
  );

  // Strobes count only when addressed and idle
  wire idle     = (state == ST_IDLE);
  wire cws_go   = cws_lead & adr_lvl & idle; // [RL22]
  wire dws_go   = dws_lead & adr_lvl & idle & ~single; // [RL22] [RL14]
  wire sc_ctrl_hit = (sc_lvl == sc_ctrl);
  wire load_ctrl = single ? (cws_go & sc_ctrl_hit) : cws_go; // [RL12] [RL13]
  wire load_data = single ? (cws_go & ~sc_ctrl_hit) : dws_go; // [RL12] [RL14]
  wire ignored  = (cws_lead | (dws_lead & ~single)) & adr_lvl & ~idle;

  // Word split and polarity of the incoming words
  wire [17:0] data_raw  = len18 ? prog_bus_i[17:0]
                                : {2'b00, prog_bus_i[15:0]}; // [RL3] [RL4]
  wire [17:0] data_wid  = len18 ? 18'h3_FFFF : 18'h0_FFFF;
  wire [17:0] last_bit  = len18 ? 18'h2_0000 : 18'h0_8000;
  wire [17:0] data_keep = (keep & binary) ? last_bit : 18'h0_0000; // [RL20]
  wire [17:0] ctrl_raw  = len18 ? {12'h000, prog_bus_i[23:18]}
                                : {10'h000, prog_bus_i[23:16]}; // [RL3]
  wire [17:0] ctrl_wid  = len18 ? 18'h0_003F : 18'h0_00FF;
  wire [17:0] data_fix  = psp_fix(data_raw, data_neg, data_keep,
                                  data_wid); // [RL5] [RL6]
  wire [17:0] ctrl_fix  = psp_fix(ctrl_raw, ctrl_neg, 18'h0_0000,
                                  ctrl_wid); // [RL7] [RL6]

  // Storage registers; a data word alone is enough to transfer
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      data_st <= 18'h0_0000;
      ctrl_st <= 8'h00;
    end else begin
      if (load_data) begin
        data_st <= data_fix; // [RL1]
      end
      if (load_ctrl) begin
        ctrl_st <= ctrl_fix[7:0];
      end
    end
  end

  // Remember which strobe was accepted until its trailing edge
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cws_acc <= 1'b0;
      dws_acc <= 1'b0;
    end else begin
      if (cws_go) begin
        cws_acc <= 1'b1;
      end else if (cws_trail) begin
        cws_acc <= 1'b0;
      end
      if (dws_go) begin
        dws_acc <= 1'b1;
      end else if (dws_trail) begin
        dws_acc <= 1'b0;
      end
    end
  end

  // Trailing edge of the selected strobe starts the transfer
  wire trg_cws = (trg_sel == `PSP_TRG_CWS) | (trg_sel == `PSP_TRG_ANY);
  wire trg_dws = (trg_sel == `PSP_TRG_DWS) | (trg_sel == `PSP_TRG_ANY);
  wire trigger = (trg_cws & cws_trail & cws_acc) |
                 (trg_dws & dws_trail & dws_acc); // [RL19]

  // Transfer sequencer: delay, then serial time, then apply
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (trigger) begin
          next_state = ST_DELAY; // [RL23]
        end
      end
      ST_DELAY: begin
        if (cnt == DLY_CYC - 12'h001) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cnt == XFER_CYC - 12'h001) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire apply = (state == ST_SHIFT) && (next_state == ST_IDLE);

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= 12'h000;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        cnt <= 12'h000;
      end else if (!idle) begin
        cnt <= cnt + 12'h001;
      end
    end
  end

  // Polarity bit source
  reg pol_bit;
  always @* begin
    case (pol_sel)
      `PSP_POL_BCD18: pol_bit = data_st[17];
      `PSP_POL_CTRL:  pol_bit = ctrl_st[1];
      `PSP_POL_BIN16: pol_bit = data_st[15];
      default:        pol_bit = 1'b0;
    endcase
  end

  // Data, control and polarity outputs hold until the transfer completes
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      out_data_o     <= 18'h0_0000;
      out_ctrl_o     <= 8'h00;
      out_polarity_o <= 1'b0;
      standby_o      <= 1'b1;
      xfer_done_o    <= 1'b0;
      ready_o        <= 1'b0;
    end else begin
      xfer_done_o <= apply;
      if (apply) begin
        out_data_o     <= data_st; // [RL23]
        out_ctrl_o     <= ctrl_st;
        out_polarity_o <= pol_bit; // [RL8]
      end
      if (!so_sync) begin
        standby_o <= so_stby ? so_lvl : ~so_lvl; // [RL9] [RL11]
      end else if (apply) begin
        standby_o <= so_stby ? ctrl_st[0] : ~ctrl_st[0]; // [RL10] [RL11]
      end
      // Low from an accepted strobe until the output settles
      ready_o <= (next_state == ST_IDLE) & ~trigger &
                 ~(cws_acc | dws_acc | cws_go | dws_go); // [RL24]
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  wire apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  wire stat_w = apb_wr & (paddr_i == `PSP_OFF_STAT);
  wire runt_ev = (cws_runt & cws_acc) | (dws_runt & dws_acc);

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      runt_flag <= 1'b0;
      ign_flag  <= 1'b0;
    end else begin
      if (runt_ev) begin
        runt_flag <= 1'b1;
      end else if (stat_w && pwdata_i[`PSP_ST_RUNT]) begin
        runt_flag <= 1'b0;
      end
      if (ignored) begin
        ign_flag <= 1'b1;
      end else if (stat_w && pwdata_i[`PSP_ST_IGN]) begin
        ign_flag <= 1'b0;
      end
    end
  end

  // APB read mux and decode
  reg [31:0] rd_val;
  reg        rd_hit;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr_i)
      `PSP_OFF_CFG:  rd_val = {16'h0000, cfg};
      `PSP_OFF_STAT: rd_val = {26'h000_0000, adr_lvl, ign_flag, runt_flag,
                               standby_o, ~idle, ready_o};
      `PSP_OFF_DATA: rd_val = {14'h0000, data_st};
      `PSP_OFF_CTRL: rd_val = {24'h00_0000, ctrl_st};
      default:       rd_hit = 1'b0;
    endcase
  end

  // One wait state so the answer comes straight from flops
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      cfg       <= `PSP_CFG_RESET;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
      if (psel_i && penable_i && !pready_o) begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_val;
        pslverr_o <= ~rd_hit;
      end else begin
        prdata_o  <= 32'h0000_0000;
        pslverr_o <= 1'b0;
      end
      if (apb_wr && paddr_i == `PSP_OFF_CFG) begin
        cfg <= pwdata_i[15:0];
      end
    end
  end

endmodule

// ===== bench/psp_port_sva.sv
`timescale 1ns/1ps
module psp_port_sva (
  input wire        clock_i,
  input wire        rstn_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        ready_o,
  input wire [17:0] out_data_o,
  input wire [7:0]  out_ctrl_o,
  input wire        out_polarity_o,
  input wire        xfer_done_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  reg [11:0] low_cnt;

  // Cycles spent not ready; a stuck sequencer would run this up
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i)
      low_cnt <= 12'h000;
    else
      low_cnt <= ready_o ? 12'h000 : low_cnt + 12'h001;
  end

  sequence s_req;
    (psel_i && !penable_i) ##1 (psel_i && penable_i);
  endsequence
  sequence s_back;
    (ready_o && !$past(ready_o)) ##1 (ready_o && !xfer_done_o);
  endsequence

  AST_PREADY_WAIT: assert property (s_req |=> pready_o)
    else $error("pready late");
  AST_PREADY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("pready held");
  AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside answer");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("pslverr alone");
  AST_DATA_AT_END: assert property ($changed(out_data_o) |-> xfer_done_o)
    else $error("data moved early");
  AST_CTRL_AT_END: assert property ($changed(out_ctrl_o) |-> xfer_done_o)
    else $error("control moved early");
  AST_POL_AT_END: assert property ($changed(out_polarity_o) |-> xfer_done_o)
    else $error("polarity moved early");
  AST_DONE_READY: assert property (xfer_done_o |-> s_back)
    else $error("ready not back after transfer");
  AST_DONE_BUSY: assert property (xfer_done_o |-> !$past(ready_o, 100))
    else $error("ready high during transfer");
  AST_LOW_BOUND: assert property (low_cnt < 12'hd48)
    else $error("ready low too long");
endmodule

bind psp_port psp_port_sva i_psp_port_sva (.clock_i(clock_i),
  .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ready_o(ready_o), .out_data_o(out_data_o), .out_ctrl_o(out_ctrl_o),
  .out_polarity_o(out_polarity_o), .xfer_done_o(xfer_done_o));

// ===== bench/psp_src.sv
`timescale 1ns/1ps
module psp_src (
  input  wire        clock_i,
  output reg  [23:0] prog_bus_o,
  output reg         cws_o,
  output reg         dws_o,
  output reg         strobe_ctl_o,
  output reg         addr_en_o
);
  reg cws_neg;
  reg dws_neg;

  // Power-up idle: positive strobes, address high
  initial begin
    cws_neg = 1'b0;
    dws_neg = 1'b0;
    prog_bus_o = 24'h00_0000;
    cws_o = 1'b0;
    dws_o = 1'b0;
    strobe_ctl_o = 1'b0;
    addr_en_o = 1'b1;
  end

  // Strobe sense and address; strobes rest at idle level
  task set_lines(input c, input d, input a);
    begin
      @(posedge clock_i);
      cws_neg = c;
      dws_neg = d;
      cws_o <= c;
      dws_o <= d;
      addr_en_o <= a;
    end
  endtask

  // Word settles first, strobe well past the 500 ns floor
  task pulse(input use_dws, input [23:0] w, input ctl);
    begin
      @(posedge clock_i);
      prog_bus_o <= w;
      strobe_ctl_o <= ctl;
      repeat (2) @(posedge clock_i);
      if (use_dws)
        dws_o <= ~dws_neg;
      else
        cws_o <= ~cws_neg;
      repeat (70) @(posedge clock_i);
      cws_o <= cws_neg;
      dws_o <= dws_neg;
      repeat (3) @(posedge clock_i);
      // Released bus must not look like the old word
      prog_bus_o <= ~w;
      strobe_ctl_o <= ~ctl;
    end
  endtask
endmodule

// ===== bench/psp_port_bench.sv
`timescale 1ns/1ps
`include "psp_consts.vh"
module psp_port_bench;
  reg         clock_i = 1'b0;
  reg         rstn_i = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg         stby_op = 1'b0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [23:0] bus;
  wire        cws;
  wire        dws;
  wire        sctl;
  wire        aen;
  wire        ready_o;
  wire [17:0] odata;
  wire [7:0]  octrl;
  wire        opol;
  wire        stby;
  wire        done;
  integer     err_count = 0;
  integer     checked = 0;
  integer     cyc = 0;
  reg  [31:0] r;
  reg         e;

  // 125 MHz
  always #4 clock_i = ~clock_i;

  psp_src i_psp_src (.clock_i(clock_i), .prog_bus_o(bus), .cws_o(cws),
    .dws_o(dws), .strobe_ctl_o(sctl), .addr_en_o(aen));

  psp_port i_psp_port (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .prog_bus_i(bus), .cws_i(cws), .dws_i(dws),
    .strobe_ctl_i(sctl), .addr_en_i(aen), .stby_op_i(stby_op),
    .ready_o(ready_o), .out_data_o(odata), .out_ctrl_o(octrl),
    .out_polarity_o(opol), .standby_o(stby), .xfer_done_o(done));

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Request held until pready is seen at an edge
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1) @(posedge clock_i);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Bounded wait; outputs read in the pulse cycle
  task wait_done;
    integer k;
    begin
      k = 0;
      @(posedge clock_i);
      while (done !== 1'b1 && k < 4000) begin
        @(posedge clock_i);
        k = k + 1;
      end
      chk({31'h0, done}, 32'h0000_0001);
    end
  endtask

  // Ready stays up and no transfer ends
  task quiet(input integer n);
    integer k;
    reg     bad;
    begin
      bad = 1'b0;
      for (k = 0; k < n; k = k + 1) begin
        @(posedge clock_i);
        if (done !== 1'b0 || ready_o !== 1'b1) bad = 1'b1;
      end
      chk({31'h0, bad}, 32'h0000_0000);
    end
  endtask

  task t_regs;
    begin
      apb(1'b0, `PSP_OFF_CFG, 32'h0);
      chk(r, 32'h0000_0000);
      apb(1'b0, `PSP_OFF_STAT, 32'h0);
      chk(r & 32'h0000_0007, 32'h0000_0005);
      apb(1'b1, `PSP_OFF_CFG, 32'hFFFF_FFFF);
      apb(1'b0, `PSP_OFF_CFG, 32'h0);
      chk(r, 32'h0000_FFFF);
      apb(1'b0, 8'h10, 32'h0);
      chk({r[30:0], e}, 32'h0000_0001);
      $display("t_regs done");
    end
  endtask

  // BCD 16+8, sync standby, polarity from control word
  task t_dual;
    begin
      apb(1'b1, `PSP_OFF_CFG, 32'h0000_20D0);
      i_psp_src.pulse(1'b1, 24'h5A_1234, 1'b0);
      wait_done;
      i_psp_src.pulse(1'b0, 24'h5A_9999, 1'b0);
      wait_done;
      chk({16'h0, odata[15:0]}, 32'h0000_1234);
      chk({24'h0, octrl}, 32'h0000_005A);
      chk({31'h0, opol}, 32'h0000_0001);
      chk({31'h0, stby}, 32'h0000_0000);
      $display("t_dual done");
    end
  endtask

  // Binary negative-true, falling strobes, kept sign bit
  task t_bin;
    begin
      // Unaddressed while the strobe sense flips, so nothing loads
      i_psp_src.set_lines(1'b1, 1'b1, 1'b0);
      apb(1'b1, `PSP_OFF_CFG, 32'h0000_5C2E);
      i_psp_src.set_lines(1'b1, 1'b1, 1'b1);
      i_psp_src.pulse(1'b0, 24'hC3_0000, 1'b0);
      while (ready_o !== 1'b1) @(posedge clock_i);
      i_psp_src.pulse(1'b1, 24'h00_8001, 1'b0);
      wait_done;
      chk({16'h0, odata[15:0]}, 32'h0000_FFFE);
      chk({24'h0, octrl}, 32'h0000_003C);
      chk({31'h0, opol}, 32'h0000_0001);
      $display("t_bin done");
    end
  endtask

  // Single strobe 18+6, address low-active, busy refusal
  task t_single;
    begin
      i_psp_src.set_lines(1'b1, 1'b1, 1'b0);
      i_psp_src.set_lines(1'b0, 1'b0, 1'b0);
      apb(1'b1, `PSP_OFF_CFG, 32'h0000_8103);
      i_psp_src.set_lines(1'b0, 1'b0, 1'b1);
      i_psp_src.pulse(1'b0, 24'h00_0F0F, 1'b1);
      quiet(200);
      i_psp_src.set_lines(1'b0, 1'b0, 1'b0);
      i_psp_src.pulse(1'b0, 24'h02_5555, 1'b1);
      i_psp_src.pulse(1'b0, 24'h01_1111, 1'b1);
      wait_done;
      chk({14'h0, odata}, 32'h0002_5555);
      chk({31'h0, opol}, 32'h0000_0001);
      quiet(300);
      apb(1'b0, `PSP_OFF_STAT, 32'h0);
      chk(r & 32'h0000_0010, 32'h0000_0010);
      i_psp_src.pulse(1'b0, 24'hFC_0000, 1'b0);
      wait_done;
      chk({14'h0, odata}, 32'h0002_5555);
      $display("t_single done");
    end
  endtask

  // Async standby line, both senses
  task t_stby;
    begin
      apb(1'b1, `PSP_OFF_CFG, 32'h0000_0000);
      stby_op <= 1'b1;
      repeat (6) @(posedge clock_i);
      chk({31'h0, stby}, 32'h0000_0000);
      apb(1'b1, `PSP_OFF_CFG, 32'h0000_0080);
      repeat (6) @(posedge clock_i);
      chk({31'h0, stby}, 32'h0000_0001);
      stby_op <= 1'b0;
      repeat (6) @(posedge clock_i);
      chk({31'h0, stby}, 32'h0000_0000);
      $display("t_stby done");
    end
  endtask

  // Dual strobe with the strobe control select set; control strobe loads the control word
  task t_sc;
    begin
      apb(1'b1, `PSP_OFF_CFG, 32'h0000_0203);
      i_psp_src.set_lines(1'b0, 1'b0, 1'b1);
      i_psp_src.pulse(1'b0, 24'h54_0000, 1'b1);
      wait_done;
      chk({24'h0, octrl}, 32'h0000_0015);
      chk({14'h0, odata}, 32'h0002_5555);
      $display("t_sc done");
    end
  endtask

  // Tests need well under 30000 cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end

  initial begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_regs;
    t_dual;
    t_bin;
    t_single;
    t_stby;
    t_sc;
    tally_and_finish;
  end
endmodule
